/* bench/swd_core_tb_top.sv */
// Self-checking testbench for the system watchdog core
`timescale 1ns/1ns
module swd_core_tb_top;
    import swd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic xtal_ok = 1'b1;
    logic xtal_tick = 1'b0;
    logic active_mode = 1'b0;
    logic otp_unlock = 1'b0;
    logic seq_pd_step = 1'b0;
    logic gpo_seq_en = 1'b0;
    logic ext_kick_en = 1'b0;
    logic kick_on = 1'b0;
    logic hold_high = 1'b0;
    logic active_entry_ok, shutdown_req, stay_powered_down;
    logic sequenced_output_pin, irq_out, first_general_pin;
    logic [4:0] tick_cnt = 5'h00;
    int sd_cnt = 0;
    int s0;
    int n_errors = 0;
    int n_tests = 0;

    // Clock, crystal tick every 32 cycles, shutdown pulse count
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        tick_cnt <= tick_cnt + 5'h01;
        xtal_tick <= xtal_ok && tick_cnt == 5'h1f;
        if (shutdown_req === 1'b1) sd_cnt <= sd_cnt + 1;
    end

    // Period of 8 base ticks keeps the run short
    swd_core #(.UNIT_TICKS(16'h0004)) swd_core_inst (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .xtal_ok(xtal_ok), .xtal_tick(xtal_tick),
        .active_mode(active_mode), .otp_unlock(otp_unlock),
        .seq_pd_step(seq_pd_step), .gpo_seq_en(gpo_seq_en),
        .active_entry_ok(active_entry_ok), .shutdown_req(shutdown_req),
        .stay_powered_down(stay_powered_down),
        .sequenced_output_pin(sequenced_output_pin),
        .ext_kick_en(ext_kick_en), .first_general_pin(first_general_pin),
        .irq_out(irq_out));
    swd_host_model swd_host_model_inst (
        .sys_clk(sys_clk), .rst(rst), .kick_on(kick_on),
        .hold_high(hold_high), .first_general_pin(first_general_pin));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, e);
    endtask : rdc

    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(negedge sys_clk);
        check(8'(s), 8'h01);
    endtask : wait_hi

    task automatic arm;
        @(negedge sys_clk);
        active_mode = 1'b0;
        @(negedge sys_clk);
        active_mode = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask : arm

    task automatic t_reset_values;
        rdc(OFS_SCALE_CTRL, 8'h01);
        rdc(OFS_SYS_CTRL_SECOND, 8'h60);
        rdc(OFS_MASK_FIRST, 8'h00);
        rdc(OFS_FAULT_RECORD, 8'h00);
        rdc(OFS_EVENT_FIRST, 8'h00);
        rdc(9'h0ff, 8'h00);
    endtask : t_reset_values

    task automatic t_first_kick;
        arm();
        check(8'(active_entry_ok), 8'h00);
        wr(OFS_CMD_TRIGGER, 8'h01);
        @(negedge sys_clk);
        check(8'(active_entry_ok), 8'h01);
        rdc(OFS_CMD_TRIGGER, 8'h00);
    endtask : t_first_kick

    task automatic t_pin_service;
        s0 = sd_cnt;
        ext_kick_en = 1'b1;
        kick_on = 1'b1;
        repeat (600) @(negedge sys_clk);
        check(8'(sd_cnt - s0), 8'h00);
        rdc(OFS_EVENT_FIRST, 8'h00);
        kick_on = 1'b0;
    endtask : t_pin_service

    task automatic t_warn_and_timeout;
        gpo_seq_en = 1'b1;
        seq_pd_step = 1'b1;
        wr(OFS_CMD_TRIGGER, 8'h01);
        repeat (90) @(negedge sys_clk);
        check(8'(irq_out), 8'h00);
        wait_hi(irq_out, 60);
        rdc(OFS_EVENT_FIRST, 8'h08);
        wr(OFS_MASK_FIRST, 8'h08);
        repeat (2) @(negedge sys_clk);
        check(8'(irq_out), 8'h00);
        rdc(OFS_EVENT_FIRST, 8'h08);
        wr(OFS_EVENT_FIRST, 8'h08);
        rdc(OFS_EVENT_FIRST, 8'h00);
        wr(OFS_MASK_FIRST, 8'h00);
        wait_hi(shutdown_req, 200);
        repeat (3) @(negedge sys_clk);
        check(8'(sequenced_output_pin), 8'h01);
        check(8'(stay_powered_down), 8'h00);
        rdc(OFS_FAULT_RECORD, 8'h01);
        wr(OFS_FAULT_RECORD, 8'h01);
        rdc(OFS_FAULT_RECORD, 8'h00);
        seq_pd_step = 1'b0;
        wr(OFS_EVENT_FIRST, 8'h08);
        check(8'(sequenced_output_pin), 8'h00);
    endtask : t_warn_and_timeout

    task automatic t_lock;
        arm();
        wr(OFS_CMD_TRIGGER, 8'h01);
        wr(OFS_SCALE_CTRL, 8'h00);
        rdc(OFS_SCALE_CTRL, 8'h01);
        otp_unlock = 1'b1;
        s0 = sd_cnt;
        wr(OFS_SCALE_CTRL, 8'h00);
        rdc(OFS_SCALE_CTRL, 8'h00);
        repeat (400) @(negedge sys_clk);
        check(8'(sd_cnt - s0), 8'h00);
        otp_unlock = 1'b0;
    endtask : t_lock

    task automatic t_level;
        wr(OFS_SCALE_CTRL, 8'h09);
        hold_high = 1'b1;
        s0 = sd_cnt;
        arm();
        repeat (700) @(negedge sys_clk);
        check(8'(sd_cnt - s0), 8'h00);
        check(8'(active_entry_ok), 8'h01);
    endtask : t_level

    task automatic t_retry_slow;
        xtal_ok = 1'b0;
        wr(OFS_SYS_CTRL_SECOND, 8'h20);
        rdc(OFS_SYS_CTRL_SECOND, 8'h20);
        hold_high = 1'b0;
        s0 = sd_cnt;
        arm();
        wr(OFS_CMD_TRIGGER, 8'h01);
        repeat (20000) @(negedge sys_clk);
        check(8'(sd_cnt - s0), 8'h00);
        wait_hi(shutdown_req, 6000);
        repeat (2) @(negedge sys_clk);
        check(8'(stay_powered_down), 8'h01);
    endtask : t_retry_slow

    task automatic complete_run;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog against a hang, well past the 30k-cycle run
    initial begin
        #500_000;
        n_errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_reset_values();
        t_first_kick();
        t_pin_service();
        t_warn_and_timeout();
        t_lock();
        t_level();
        t_retry_slow();
        complete_run();
    end
endmodule : swd_core_tb_top

/* bench/swd_host_model.sv */
// Host model servicing the watchdog through the kick pin
`timescale 1ns/1ns
module swd_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Service control
    input wire logic kick_on,
    input wire logic hold_high,
    // Kick pin
    output logic first_general_pin
);
    logic [5:0] gap = 6'h00;
    initial first_general_pin = 1'b0;
    // Pulse every 64 cycles, well inside the period, or hold high
    always @(negedge sys_clk) begin
        gap <= (rst || !kick_on) ? 6'h00 : gap + 6'h01;
        first_general_pin <= hold_high || (kick_on && gap == 6'h3f);
    end
endmodule : swd_host_model

/* logic/swd_core.sv */
// System watchdog: countdown, warning, timeout, retries, registers
`timescale 1ns/1ns
module swd_core
    import swd_pkg::*;
#(
    parameter logic [15:0] UNIT_TICKS = UNIT_TICKS_DEF
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // Clock sources
    input wire logic xtal_ok,
    input wire logic xtal_tick,
    // Power manager and sequencer
    input wire logic active_mode,
    input wire logic otp_unlock,
    input wire logic seq_pd_step,
    input wire logic gpo_seq_en,
    output logic active_entry_ok,
    output logic shutdown_req,
    output logic stay_powered_down,
    output logic sequenced_output_pin,
    // External kick pin
    input wire logic ext_kick_en,
    input wire logic first_general_pin,
    // Interrupt
    output logic irq_out
);

    logic base_tick;
    logic running;
    logic active_q;
    logic ext_q;
    logic pending;
    logic timeout_fault_flag;
    logic timeout_warn_event;
    logic timeout_warn_mask;
    logic kick_level_mode;
    logic [2:0] period_scale_field;
    logic [1:0] retry_limit_field;
    logic [1:0] retry_left;
    logic [23:0] elapsed;

    swd_timebase u_timebase (
        .sys_clk(sys_clk),
        .rst(rst),
        .xtal_ok(xtal_ok),
        .xtal_tick(xtal_tick),
        .base_tick(base_tick),
        .src_is_xtal()
    );

    // Register write decode
    wire wr_fault = reg_wr && (reg_addr == OFS_FAULT_RECORD);
    wire wr_event = reg_wr && (reg_addr == OFS_EVENT_FIRST);
    wire wr_mask = reg_wr && (reg_addr == OFS_MASK_FIRST);
    wire wr_ctrl_b = reg_wr && (reg_addr == OFS_SYS_CTRL_SECOND);
    wire wr_scale = reg_wr && (reg_addr == OFS_SCALE_CTRL);
    wire wr_cmd = reg_wr && (reg_addr == OFS_CMD_TRIGGER);
    wire [2:0] new_scale = reg_wdata[LSB_SCALE +: 3];
    // Stopping by scale zero is refused while running and locked
    wire stop_req = wr_scale && (new_scale == 3'h0);
    wire stop_ok = stop_req && (otp_unlock || !running);
    wire scale_wr_ok = wr_scale && (!stop_req || stop_ok);

    // Service sources
    wire reg_kick = wr_cmd && reg_wdata[BIT_KICK];
    wire ext_rise = ext_kick_en && first_general_pin && !ext_q;
    wire ext_hold = ext_kick_en && kick_level_mode
        && first_general_pin;
    wire kick = reg_kick || ext_rise || ext_hold;

    // Period and half period in base ticks
    wire [23:0] period = {8'h00, UNIT_TICKS} << period_scale_field;
    wire [23:0] half = period >> 1;
    wire [23:0] elapsed_inc = elapsed + 24'h00_0001;
    wire count_step = running && base_tick && !kick;
    wire warn_hit = count_step && (elapsed_inc == half);
    wire to_hit = count_step && (elapsed_inc == period);
    wire arm = active_mode && !active_q && !stay_powered_down
        && (period_scale_field != 3'h0);

    // Read mux
    wire [7:0] rd_fault = {7'h00, timeout_fault_flag};
    wire [7:0] rd_event = {4'h0, timeout_warn_event, 3'h0};
    wire [7:0] rd_mask = {4'h0, timeout_warn_mask, 3'h0};
    wire [7:0] rd_ctrl_b = {1'b0, retry_limit_field, 5'h00};
    wire [7:0] rd_scale = {4'h0, kick_level_mode, period_scale_field};
    wire [7:0] next_rdata =
        (reg_addr == OFS_FAULT_RECORD) ? rd_fault :
        (reg_addr == OFS_EVENT_FIRST) ? rd_event :
        (reg_addr == OFS_MASK_FIRST) ? rd_mask :
        (reg_addr == OFS_SYS_CTRL_SECOND) ? rd_ctrl_b :
        (reg_addr == OFS_SCALE_CTRL) ? rd_scale :
        8'h00; // Kick bit and unmapped read as zero

    // Read data register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Control fields
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_scale_field <= SCALE_RST;
            kick_level_mode <= LEVEL_MODE_RST;
            timeout_warn_mask <= WARN_MASK_RST;
            retry_limit_field <= RETRY_RST;
        end else begin
            if (scale_wr_ok) begin
                period_scale_field <= new_scale;
                kick_level_mode <= reg_wdata[BIT_LEVEL_MODE];
            end
            if (wr_mask) begin
                timeout_warn_mask <= reg_wdata[BIT_WARN_MASK];
            end
            if (wr_ctrl_b) begin
                retry_limit_field <= reg_wdata[LSB_RETRY +: 2];
            end
        end
    end

    // Sticky flags, set beats clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timeout_fault_flag <= 1'b0;
            timeout_warn_event <= 1'b0;
        end else begin
            if (to_hit) begin
                timeout_fault_flag <= 1'b1;
            end else if (wr_fault && reg_wdata[BIT_TIMEOUT_FAULT]) begin
                timeout_fault_flag <= 1'b0;
            end
            if (warn_hit) begin
                timeout_warn_event <= 1'b1;
            end else if (wr_event && reg_wdata[BIT_WARN_EVENT]) begin
                timeout_warn_event <= 1'b0;
            end
        end
    end

    // Run state, countdown and first-kick tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            running <= 1'b0;
            active_q <= 1'b0;
            ext_q <= 1'b0;
            elapsed <= 24'h00_0000;
            active_entry_ok <= 1'b0;
        end else begin
            active_q <= active_mode;
            ext_q <= first_general_pin;
            if (arm) begin
                running <= 1'b1;
            end else if (to_hit || stop_ok) begin
                running <= 1'b0;
            end
            if (!running || kick || to_hit) begin
                elapsed <= 24'h00_0000;
            end else if (base_tick) begin
                elapsed <= elapsed_inc;
            end
            if (arm) begin
                active_entry_ok <= 1'b0;
            end else if (kick && running) begin
                active_entry_ok <= 1'b1;
            end
        end
    end

    // Shutdown request, retries and secondary reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shutdown_req <= 1'b0;
            pending <= 1'b0;
            retry_left <= RETRY_RST;
            stay_powered_down <= 1'b0;
            sequenced_output_pin <= 1'b0;
        end else begin
            shutdown_req <= to_hit;
            if (to_hit) begin
                pending <= 1'b1;
            end else if (arm) begin
                pending <= 1'b0;
            end
            if (wr_ctrl_b) begin
                retry_left <= reg_wdata[LSB_RETRY +: 2];
            end else if (to_hit && retry_left != 2'h0) begin
                retry_left <= retry_left - 2'h1;
            end
            if (to_hit && retry_left <= 2'h1) begin
                stay_powered_down <= 1'b1;
            end
            sequenced_output_pin <= gpo_seq_en && pending
                && seq_pd_step;
        end
    end

    // Interrupt output
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= timeout_warn_event && !timeout_warn_mask;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_timeout_fault;
        to_hit |=> timeout_fault_flag && shutdown_req && !running;
    endproperty
    a_timeout_fault: assert property (p_timeout_fault)
        else $error("timeout did not log fault and request shutdown");

    sequence s_pd_window;
        gpo_seq_en && pending && seq_pd_step;
    endsequence
    property p_sec_reset;
        s_pd_window ##1 s_pd_window |-> sequenced_output_pin;
    endproperty
    a_sec_reset: assert property (p_sec_reset)
        else $error("secondary reset not held in power-down step");

    property p_locked;
        running && !otp_unlock && !to_hit |=> running;
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked watchdog stopped");

    property p_first_kick;
        arm |=> running && !active_entry_ok;
    endproperty
    a_first_kick: assert property (p_first_kick)
        else $error("arming did not demand a first kick");

    property p_warn;
        warn_hit |=> timeout_warn_event && running;
    endproperty
    a_warn: assert property (p_warn)
        else $error("warning event missed at half period");

    property p_reg_kick;
        running && reg_kick && !to_hit |=> elapsed == 24'h00_0000;
    endproperty
    a_reg_kick: assert property (p_reg_kick)
        else $error("register kick did not restart countdown");

    property p_level_hold;
        running && ext_kick_en && kick_level_mode && first_general_pin
            |-> !to_hit && !warn_hit;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("held kick level let the watchdog expire");

    property p_retry;
        to_hit && retry_left == 2'h1 |=> stay_powered_down
            && retry_left == 2'h0;
    endproperty
    a_retry: assert property (p_retry)
        else $error("last retry did not freeze power-down");

    property p_irq_mask;
        timeout_warn_event && !timeout_warn_mask |=> irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("unmasked event did not raise interrupt");

    property p_kick_read;
        reg_rd && reg_addr == OFS_CMD_TRIGGER |=> reg_rdata == 8'h00;
    endproperty
    a_kick_read: assert property (p_kick_read)
        else $error("kick bit did not read back as zero");

endmodule : swd_core

/* logic/swd_pkg.sv */
// Constants shared by the system watchdog block
package swd_pkg;

    // Register port geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [8:0] OFS_FAULT_RECORD = 9'h005;
    localparam logic [8:0] OFS_EVENT_FIRST = 9'h006;
    localparam logic [8:0] OFS_MASK_FIRST = 9'h00a;
    localparam logic [8:0] OFS_SYS_CTRL_SECOND = 9'h00f;
    localparam logic [8:0] OFS_SCALE_CTRL = 9'h011;
    localparam logic [8:0] OFS_CMD_TRIGGER = 9'h013;

    // Field positions
    localparam int BIT_TIMEOUT_FAULT = 0;
    localparam int BIT_WARN_EVENT = 3;
    localparam int BIT_WARN_MASK = 3;
    localparam int BIT_KICK = 0;
    localparam int BIT_LEVEL_MODE = 3;
    localparam int LSB_SCALE = 0;
    localparam int LSB_RETRY = 5;

    // Values after reset
    localparam logic [2:0] SCALE_RST = 3'h1;
    localparam logic [1:0] RETRY_RST = 2'h3;
    localparam logic WARN_MASK_RST = 1'b0;
    localparam logic LEVEL_MODE_RST = 1'b0;

    // Time base: internal slow clock derived from the system clock
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int SLOW_CLK_HZ = 32_000;
    localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;
    localparam logic [11:0] SLOW_DIV_LAST = 12'(SLOW_DIV - 1);

    // Base ticks per unit period (scaled by 2**scale)
    localparam logic [15:0] UNIT_TICKS_DEF = 16'h0800;

endpackage : swd_pkg

/* logic/swd_timebase.sv */
// Watchdog time base with automatic clock source selection
`timescale 1ns/1ns
module swd_timebase
    import swd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Crystal-derived 32 kHz source
    input wire logic xtal_ok,
    input wire logic xtal_tick,
    // Selected tick
    output logic base_tick,
    output logic src_is_xtal
);

    logic [11:0] div_cnt;
    wire div_wrap = (div_cnt == SLOW_DIV_LAST);

    // Internal slow clock divider
    always_ff @(posedge sys_clk) begin
        if (rst || div_wrap) begin
            div_cnt <= 12'h000;
        end else begin
            div_cnt <= div_cnt + 12'h001;
        end
    end

    // Automatic source choice, no software involved
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            base_tick <= 1'b0;
            src_is_xtal <= 1'b0;
        end else begin
            src_is_xtal <= xtal_ok;
            base_tick <= xtal_ok ? xtal_tick : div_wrap;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_src_select;
        xtal_ok |=> base_tick == $past(xtal_tick);
    endproperty
    a_src_select: assert property (p_src_select)
        else $error("tick does not follow crystal source");

    property p_src_internal;
        !xtal_ok |=> base_tick == $past(div_wrap);
    endproperty
    a_src_internal: assert property (p_src_internal)
        else $error("tick does not follow internal slow clock");

endmodule : swd_timebase
